// ---- src/sto_regs.svh ----
`ifndef STO_REGS_SVH
`define STO_REGS_SVH
// Discrepancy windows in their own units.
`define STO_DISC_NEW_MS 1000
`define STO_DISC_OLD_MS 10
// Longest reaction time from a stop demand to torque off.
`define STO_REACT_MS 100
// Control clock rate.
`define STO_CLK_KHZ 200000
// Discrepancy windows as clock-cycle counts.
`define STO_DISC_NEW_CYC (`STO_DISC_NEW_MS * `STO_CLK_KHZ)
`define STO_DISC_OLD_CYC (`STO_DISC_OLD_MS * `STO_CLK_KHZ)
// Reaction time in cycles.
`define STO_REACT_CYC (`STO_REACT_MS * `STO_CLK_KHZ)
// Input filter length in cycles.
`define STO_FILT_CYC 4
// Lowest firmware revision that uses the long window.
`define STO_NEW_REV 4'h5
`endif

// ---- src/sto_pkg.sv ----
package sto_pkg;
  typedef enum logic [1:0] {
    STO_RUN = 2'b00,
    STO_WAIT = 2'b01,
    STO_OPEN = 2'b10,
    STO_MISMATCH = 2'b11
  } sto_state_t;
endpackage

// ---- src/sto_sync.sv ----
`timescale 1ns/1ps
`include "sto_regs.svh"
// Two-stage synchroniser followed by an agreement filter for one input.
module sto_sync #(
  parameter int FILT = `STO_FILT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out
);
  localparam int CNT_W = $clog2(FILT + 1);

  logic meta_q;
  logic sync_q;
  logic [CNT_W-1:0] cnt_q;

  // The first stage is read only by the second.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // The level changes only after the input has disagreed for FILT cycles.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      level_out <= 1'b0;
    end else if (sync_q == level_out) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(FILT - 1)) begin
      cnt_q <= '0;
      level_out <= sync_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// ---- src/sto_monitor.sv ----
`timescale 1ns/1ps
`include "sto_regs.svh"
// Functional notes
// - Motor may run only while both safety inputs are energized.
// - Either input dropping blocks the gate firing path.
// - Second input not following within window raises mismatch fault.
// - Second input following within window raises safety open fault.
// - Firmware revision 5 or later uses a one second window.
// - Firmware revision 4 or earlier uses a ten millisecond window.
// - Torque off starts within 100 ms of a stop demand.
// - Torque off alone only lets the motor coast to stop.
// - Firing path is cut regardless of controller commands.
// - When an external fault clears, the enable is allowed again.
module sto_monitor
  import sto_pkg::*;
#(
  parameter int DISC_NEW_CYC = `STO_DISC_NEW_CYC,
  parameter int DISC_OLD_CYC = `STO_DISC_OLD_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic safety_input_a_in,
  input wire logic safety_input_b_in,
  input wire logic [3:0] fw_rev_in,
  input wire logic open_state_fault_select_in,
  input wire logic fault_reset_in,
  input wire logic [5:0] gate_cmd_in,
  output logic [5:0] gate_out,
  output logic run_enable_out,
  output logic safe_state_out,
  output logic safety_open_fault_out,
  output logic hardware_mismatch_fault_out,
  output logic open_status_out
);
  localparam int CW = $clog2(DISC_NEW_CYC + 1);

  logic in_a;
  logic in_b;
  sto_state_t state_q;
  logic [CW-1:0] timer_q;
  logic [CW-1:0] window_q;
  logic both_on;
  logic both_off;
  logic one_off;

  // Pin inputs are synchronised and filtered before any decision.
  sto_sync u_sync_a (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(safety_input_a_in),
    .level_out(in_a)
  );

  sto_sync u_sync_b (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(safety_input_b_in),
    .level_out(in_b)
  );

  // Channel agreement terms, identical for either channel.
  assign both_on = in_a & in_b;
  assign both_off = ~in_a & ~in_b;
  assign one_off = in_a ^ in_b;

  // Window length chosen by firmware revision.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      window_q <= CW'(DISC_OLD_CYC);
    end else if (fw_rev_in >= `STO_NEW_REV) begin
      window_q <= CW'(DISC_NEW_CYC);
    end else begin
      window_q <= CW'(DISC_OLD_CYC);
    end
  end

  // Main supervision state machine with the discrepancy timer.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= STO_OPEN;
      timer_q <= '0;
    end else begin
      case (state_q)
        STO_RUN: begin
          timer_q <= '0;
          if (both_off) begin
            state_q <= STO_OPEN;
          end else if (one_off) begin
            state_q <= STO_WAIT;
          end
        end
        STO_WAIT: begin
          timer_q <= timer_q + 1'b1;
          if (both_off) begin
            state_q <= STO_OPEN;
          end else if (both_on) begin
            state_q <= STO_RUN;
          end else if (timer_q >= window_q - 1'b1) begin
            state_q <= STO_MISMATCH;
          end
        end
        STO_OPEN: begin
          timer_q <= '0;
          if (both_on) begin
            state_q <= STO_RUN;
          end else if (one_off) begin
            state_q <= STO_MISMATCH;
          end
        end
        STO_MISMATCH: begin
          timer_q <= '0;
          // A reset counts only while both inputs are on; none is stored.
          if (both_on && fault_reset_in) begin
            state_q <= STO_RUN;
          end
        end
        default: begin
          state_q <= STO_OPEN;
          timer_q <= '0;
        end
      endcase
    end
  end

  // Gate path also looks at the filtered inputs, so it is cut at once.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gate_out <= 6'h00;
      run_enable_out <= 1'b0;
      safe_state_out <= 1'b1;
    end else begin
      run_enable_out <= both_on && (state_q == STO_RUN);
      safe_state_out <= !(both_on && (state_q == STO_RUN));
      // Only coasting results: all switches off, no braking pattern.
      if (both_on && (state_q == STO_RUN)) begin
        gate_out <= gate_cmd_in;
      end else begin
        gate_out <= 6'h00;
      end
    end
  end

  // Reported status flags.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      safety_open_fault_out <= 1'b0;
      hardware_mismatch_fault_out <= 1'b0;
      open_status_out <= 1'b0;
    end else begin
      hardware_mismatch_fault_out <= (state_q == STO_MISMATCH);
      safety_open_fault_out <= (state_q == STO_OPEN) &&
        open_state_fault_select_in;
      open_status_out <= (state_q == STO_OPEN) &&
        !open_state_fault_select_in;
    end
  end

  // Gates are never fired unless both inputs were on two cycles earlier.
  chk_gate_block: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !$past(both_on) |=> gate_out == 6'h00)
    else $error("gates fired with a safety input off");

  // Run is reported only after both filtered inputs were on.
  chk_run_both: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    run_enable_out |-> $past(in_a) && $past(in_b))
    else $error("run enabled without both inputs");

  // A dropped input reaches the safe state within two cycles.
  chk_reaction_time: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (!in_a || !in_b) |-> ##[1:2] safe_state_out)
    else $error("torque off too slow");

  // The mismatch state is left only by a reset with both inputs on.
  chk_mismatch_latch: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_MISMATCH && !(both_on && fault_reset_in)
    |=> state_q == STO_MISMATCH)
    else $error("mismatch fault left without reset and both inputs");

  // An expired window with one input still on gives the mismatch state.
  chk_wait_bound: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_WAIT && timer_q >= window_q - 1'b1 && one_off
    |=> state_q == STO_MISMATCH)
    else $error("window expiry missed");

  // A following input inside the window gives the open state.
  chk_follow_open: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_WAIT && both_off |=> state_q == STO_OPEN)
    else $error("following input did not give open state");

  // Either channel dropping alone starts the discrepancy timer.
  chk_sym_start: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_RUN && one_off |=> state_q == STO_WAIT)
    else $error("discrepancy timer did not start");

  // New firmware revisions select the long window.
  chk_window_sel: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    fw_rev_in >= `STO_NEW_REV |=> window_q == CW'(DISC_NEW_CYC))
    else $error("wrong discrepancy window");

  // Old firmware revisions select the short window.
  chk_window_old: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    fw_rev_in < `STO_NEW_REV |=> window_q == CW'(DISC_OLD_CYC))
    else $error("wrong short window");

  // Both inputs back on from the open state allow running again.
  chk_enable_restore: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_OPEN && both_on |=> state_q == STO_RUN)
    else $error("enable not restored");

  // One input powered from the open state latches the mismatch fault.
  chk_single_on: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    state_q == STO_OPEN && one_off |=> state_q == STO_MISMATCH)
    else $error("single powered input not flagged");

  // A reported mismatch fault always comes with the safe state.
  chk_fault_safe: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    hardware_mismatch_fault_out |-> safe_state_out && !run_enable_out)
    else $error("mismatch fault without safe state");
endmodule

// ---- dv/sto_relay_model.sv ----
`timescale 1ns/1ps
// Behavioural safety relay that powers the two channel pins of the drive.
module sto_relay_model (
  input wire logic ref_clk_in,
  input wire logic stop_in,
  input wire logic wire_fault_a_in,
  input wire logic wire_fault_b_in,
  output logic pin_a_out,
  output logic pin_b_out
);
  // One stop demand opens both contacts on the same edge, while a wiring
  // fault holds one channel unpowered on its own.
  always_ff @(posedge ref_clk_in) begin
    pin_a_out <= !(stop_in || wire_fault_a_in);
    pin_b_out <= !(stop_in || wire_fault_b_in);
  end
endmodule

// ---- dv/tb_sto_monitor.sv ----
`timescale 1ns/1ps
module tb_sto_monitor;
  logic ref_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic stop = 1'h1;
  logic flt_a = 1'h0;
  logic flt_b = 1'h0;
  logic osel = 1'h1;
  logic frst = 1'h0;
  logic pin_a, pin_b, run, safe, sof, hmf, ost;
  logic [3:0] fw_rev = 4'h5;
  logic [5:0] gcmd = 6'h00;
  logic [5:0] gate;
  logic [10:0] notes[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h9cd9;
  event seen;

  // Free-running 200 MHz clock.
  always #2.5 ref_clk_in = ~ref_clk_in;

  sto_relay_model i_relay (.ref_clk_in(ref_clk_in), .stop_in(stop),
    .wire_fault_a_in(flt_a), .wire_fault_b_in(flt_b),
    .pin_a_out(pin_a), .pin_b_out(pin_b));

  sto_monitor #(.DISC_NEW_CYC(50), .DISC_OLD_CYC(20)) i_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .safety_input_a_in(pin_a),
    .safety_input_b_in(pin_b), .fw_rev_in(fw_rev),
    .open_state_fault_select_in(osel), .fault_reset_in(frst),
    .gate_cmd_in(gcmd), .gate_out(gate), .run_enable_out(run),
    .safe_state_out(safe), .safety_open_fault_out(sof),
    .hardware_mismatch_fault_out(hmf), .open_status_out(ost));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares one observed output word with its expected value.
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n cycles and lands just after the edge, as all drives do.
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // Notes the expected word {gates, run, safe, open, mismatch, status}.
  task automatic note(input logic [5:0] g, input logic [4:0] f, input int n);
    step(n);
    notes.push_back({g, f});
    ->seen;
  endtask

  // Clears a latched mismatch with both channels powered again.
  task automatic recover();
    flt_a = 1'h0;
    flt_b = 1'h0;
    stop = 1'h0;
    note(6'h00, 5'h0a, 12);
    frst = 1'h1;
    step(2);
    frst = 1'h0;
    note(gcmd, 5'h10, 12);
  endtask

  // Takes the oldest note whenever a settled result is flagged.
  always @(seen) begin
    check({gate, run, safe, sof, hmf, ost}, notes.pop_front());
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Main sequence of scenarios.
  initial begin
    step(4);
    rst_in = 1'h0;
    note(6'h00, 5'h0c, 12);
    gcmd = 6'($random(seed)) | 6'h01;
    stop = 1'h0;
    note(gcmd, 5'h10, 12);
    $display("test power-up and run done");
    for (int ch = 0; ch < 2; ch++) begin
      fw_rev = 4'h5 | 4'($random(seed));
      flt_a = (ch == 0);
      flt_b = (ch == 1);
      note(6'h00, 5'h08, 35);
      note(6'h00, 5'h0a, 30);
      recover();
    end
    $display("test long window mismatch done");
    fw_rev = 4'($random(seed)) & 4'h4;
    osel = 1'h0;
    flt_b = 1'h1;
    step(10);
    stop = 1'h1;
    note(6'h00, 5'h09, 15);
    stop = 1'h0;
    flt_b = 1'h0;
    note(gcmd, 5'h10, 12);
    flt_a = 1'h1;
    note(6'h00, 5'h0a, 35);
    gcmd = 6'($random(seed)) | 6'h01;
    recover();
    $display("test short window done");
    stop = 1'h1;
    note(6'h00, 5'h09, 12);
    flt_a = 1'h1;
    stop = 1'h0;
    note(6'h00, 5'h0a, 12);
    frst = 1'h1;
    step(2);
    frst = 1'h0;
    flt_a = 1'h0;
    note(6'h00, 5'h0a, 12);
    recover();
    $display("test single input done");
    stop_test();
  end
endmodule
